// ### design/rwa_cfg.svh
// Constants of the display memory window and addressing command block.
// Assumes inclusion by bare name from the package and the command interpreter module.
`ifndef RWA_CFG_SVH
`define RWA_CFG_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define RWA_CMD_ENTRY    8'h11
`define RWA_CMD_WR_BW    8'h24
`define RWA_CMD_WR_RED   8'h26
`define RWA_CMD_BORDER   8'h3C
`define RWA_CMD_RD_OPT   8'h41
`define RWA_CMD_XWIN     8'h44
`define RWA_CMD_YWIN     8'h45
`define RWA_CMD_FILL_RED 8'h46
`define RWA_CMD_FILL_BW  8'h47
`define RWA_CMD_XCNT     8'h4E
`define RWA_CMD_YCNT     8'h4F
`define RWA_CMD_NOP      8'h7F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RWA_XSTART_RST   6'h00
`define RWA_XEND_RST     6'h15
`define RWA_YSTART_RST   9'h000
`define RWA_YEND_RST     9'h127
`define RWA_BORDER_RST   8'hC0
`define RWA_ENTRY_RST    3'h3
`define RWA_XCNT_RST     6'h00
`define RWA_YCNT_RST     9'h000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RWA_BD_SRC_HI    7
`define RWA_BD_SRC_LO    6
`define RWA_BD_LVL_HI    5
`define RWA_BD_LVL_LO    4
`define RWA_BD_GSCTL     2
`define RWA_BD_LUT_HI    1
`define RWA_BD_LUT_LO    0
`define RWA_ENT_AM       2
`define RWA_ENT_IDY      1
`define RWA_ENT_IDX      0
`define RWA_FILL_FIRST   7
`define RWA_FILL_H_HI    6
`define RWA_FILL_H_LO    4
`define RWA_FILL_W_HI    2
`define RWA_FILL_W_LO    0

// ----------------------------------------
// Fill extent and size code limits
// ----------------------------------------
`define RWA_FILL_COLS    22
`define RWA_FILL_ROWS    296
`define RWA_H_BAD        3'h7
`define RWA_W_MAX_OK     3'h5

`endif

// ### design/rwa_pkg.sv
// Types of the display memory window and addressing command block.
// Assumes rwa_cfg.svh sits beside it.
package rwa_pkg;
  `include "rwa_cfg.svh"

  typedef enum logic [1:0] {xfer_none, xfer_bw, xfer_red} rwa_xfer_e;
  typedef enum logic       {fill_idle, fill_run} rwa_fill_e;

  typedef enum logic [3:0] {
    bd_lut0, bd_lut1, bd_lut2, bd_lut3, bd_vcom, bd_ground,
    bd_positive_source_rail_one, bd_negative_source_rail,
    bd_positive_source_rail_two, bd_hiz
  } rwa_bd_e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] pidx;
    rwa_xfer_e  xfer;
    logic       xfer_open;
    logic [5:0] window_x_start;
    logic [5:0] window_x_end;
    logic [8:0] window_y_start;
    logic [8:0] window_y_end;
    logic [5:0] xcnt;
    logic [8:0] ycnt;
    logic [2:0] entry;
    logic       read_plane;
    logic [7:0] border;
    rwa_bd_e    border_drive_output;
    rwa_fill_e  fill;
    logic       fill_plane;
    logic       fill_first;
    logic [8:0] fill_h;
    logic [4:0] fill_w;
    logic [5:0] fx;
    logic [8:0] fy;
    logic [4:0] fxb;
    logic [8:0] fyb;
    logic       xtog;
    logic       ytog;
    logic       ram_we;
    logic       ram_plane;
    logic [5:0] ram_x;
    logic [8:0] ram_y;
    logic [7:0] ram_wdata;
    logic       busy;
  } rwa_state_s;
endpackage

// ### design/rwa_step.sv
// One axis of the memory address counter: next value inside a window.
// Assumes a combinational user; the caller registers the result.
`timescale 1ns/1ps
module rwa_step #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] cur,
  input  wire logic [W-1:0] win_lo,
  input  wire logic [W-1:0] win_hi,
  input  wire logic         up,
  output logic      [W-1:0] next_val,
  output logic              wrap
);
  always_comb begin
    if (up) begin
      wrap     = (cur >= win_hi);
      next_val = wrap ? win_lo : W'(cur + 1'b1);
    end else begin
      // Counting down the traversal begins at the high bound
      wrap     = (cur <= win_lo);
      next_val = wrap ? win_hi : W'(cur - 1'b1);
    end
  end
endmodule

// ### design/rwa_cmd.sv
// Command interpreter for display memory windows, counters, fills and border.
// Assumes the byte stream arrives already deserialised on the same clock.
`timescale 1ns/1ps
`include "rwa_cfg.svh"

// Functional notes
// - Border source field: transition, fixed level, common voltage, high impedance; resets C0h.
// - Fixed border level: ground, rail one, negative rail, rail two.
// - Transition control bit zero drives common voltage during red phases.
// - Two-bit field picks look-up table zero to three for the border.
// - Read plane bit resets zero for black/white, one selects red plane.
// - X window takes six-bit start and end, reset 00h and 15h.
// - Y window takes nine-bit start and end, low byte then bit 8.
// - Red fill writes alternating pattern; height codes decode, busy high throughout.
// - Fill width codes decode 8 to 176 pixels; 110 and 111 invalid.
// - Black/white fill matches red fill but targets black/white plane.
// - Set X counter loads six bits; resets to 00h.
// - Set Y counter loads nine bits, low byte then bit 8; resets 000h.
// - No-operation has no effect but ends a memory transfer.
// - After each data byte the counters increment for 11, decrement for 00.
// - Low direction bit governs X, high direction bit governs Y.
// - Axis bit zero advances X first, one advances Y first.
// - Data transfer writes land only inside the window rectangle; fills write the whole fill extent.
module rwa_cmd
  import rwa_pkg::*;
#(
  parameter int FILL_COLS = `RWA_FILL_COLS,
  parameter int FILL_ROWS = `RWA_FILL_ROWS
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       data_cmd,
  input  wire logic       red_phase,
  output logic            busy,
  output logic            ram_we,
  output logic            ram_plane,
  output logic [5:0]      ram_x,
  output logic [8:0]      ram_y,
  output logic [7:0]      ram_wdata,
  output logic            read_plane,
  output logic [5:0]      window_x_start,
  output logic [5:0]      window_x_end,
  output logic [8:0]      window_y_start,
  output logic [8:0]      window_y_end,
  output logic [5:0]      ram_address_counter_x,
  output logic [8:0]      ram_address_counter_y,
  output logic [1:0]      count_direction_bits,
  output logic            axis_select_bit,
  output logic            transfer_active,
  output rwa_bd_e         border_drive_output
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (FILL_COLS < 1 || FILL_COLS > 64 || FILL_ROWS < 1 || FILL_ROWS > 512) begin : g_bad
    $error("rwa_cmd: fill extent outside counter range");
  end

  localparam logic [5:0] LAST_COL = 6'(FILL_COLS - 1);
  localparam logic [8:0] LAST_ROW = 9'(FILL_ROWS - 1);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic [8:0] fill_height(input logic [2:0] code);
    unique case (code)
      3'h0:    fill_height = 9'h008;
      3'h1:    fill_height = 9'h010;
      3'h2:    fill_height = 9'h020;
      3'h3:    fill_height = 9'h040;
      3'h4:    fill_height = 9'h080;
      3'h5:    fill_height = 9'h100;
      default: fill_height = 9'h128;
    endcase
  endfunction

  // Width in bytes; eight pixels share one memory byte
  function automatic logic [4:0] fill_width(input logic [2:0] code);
    unique case (code)
      3'h0:    fill_width = 5'h01;
      3'h1:    fill_width = 5'h02;
      3'h2:    fill_width = 5'h04;
      3'h3:    fill_width = 5'h08;
      3'h4:    fill_width = 5'h10;
      default: fill_width = 5'h16;
    endcase
  endfunction

  function automatic rwa_bd_e border_pick(input logic [7:0] cfg, input logic red);
    rwa_bd_e r;
    r = bd_hiz;
    unique case (cfg[`RWA_BD_SRC_HI:`RWA_BD_SRC_LO])
      2'b00: begin
        if (!cfg[`RWA_BD_GSCTL] && red) begin
          r = bd_vcom;
        end else begin
          r = rwa_bd_e'({2'b00, cfg[`RWA_BD_LUT_HI:`RWA_BD_LUT_LO]});
        end
      end
      2'b01: begin
        unique case (cfg[`RWA_BD_LVL_HI:`RWA_BD_LVL_LO])
          2'b00: r = bd_ground;
          2'b01: r = bd_positive_source_rail_one;
          2'b10: r = bd_negative_source_rail;
          2'b11: r = bd_positive_source_rail_two;
        endcase
      end
      2'b10: r = bd_vcom;
      2'b11: r = bd_hiz;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // State and address steppers
  // ----------------------------------------
  rwa_state_s st;
  rwa_state_s next_st;
  logic [5:0] x_next;
  logic [8:0] y_next;
  logic       x_wrap;
  logic       y_wrap;

  rwa_step #(.W(6)) u_step_x (
    .cur      (st.xcnt),
    .win_lo   (st.window_x_start),
    .win_hi   (st.window_x_end),
    .up       (st.entry[`RWA_ENT_IDX]),
    .next_val (x_next),
    .wrap     (x_wrap)
  );

  rwa_step #(.W(9)) u_step_y (
    .cur      (st.ycnt),
    .win_lo   (st.window_y_start),
    .win_hi   (st.window_y_end),
    .up       (st.entry[`RWA_ENT_IDY]),
    .next_val (y_next),
    .wrap     (y_wrap)
  );

  logic in_window;
  assign in_window = st.xcnt >= st.window_x_start && st.xcnt <= st.window_x_end &&
                     st.ycnt >= st.window_y_start && st.ycnt <= st.window_y_end;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st        = st;
    next_st.ram_we = 1'b0;
    next_st.border_drive_output = border_pick(st.border, red_phase);

    if (st.fill == fill_run) begin
      // Bytes arriving during a fill are dropped; the host waits on busy
      next_st.ram_we    = 1'b1;
      next_st.ram_plane = st.fill_plane;
      next_st.ram_x     = st.fx;
      next_st.ram_y     = st.fy;
      next_st.ram_wdata = {8{st.fill_first ^ st.xtog ^ st.ytog}};
      if (st.fx == LAST_COL) begin
        next_st.fx   = 6'h00;
        next_st.fxb  = 5'h00;
        next_st.xtog = 1'b0;
        if (st.fy == LAST_ROW) begin
          next_st.fill = fill_idle;
          next_st.busy = 1'b0;
        end else begin
          next_st.fy = st.fy + 9'h001;
          if (st.fyb == 9'(st.fill_h - 9'h001)) begin
            next_st.fyb  = 9'h000;
            next_st.ytog = ~st.ytog;
          end else begin
            next_st.fyb = st.fyb + 9'h001;
          end
        end
      end else begin
        next_st.fx = st.fx + 6'h01;
        if (st.fxb == 5'(st.fill_w - 5'h01)) begin
          next_st.fxb  = 5'h00;
          next_st.xtog = ~st.xtog;
        end else begin
          next_st.fxb = st.fxb + 5'h01;
        end
      end
    end else if (byte_valid && !data_cmd) begin
      next_st.cmd  = byte_data;
      next_st.pidx = 3'h0;
      next_st.xfer_open = byte_data == `RWA_CMD_WR_BW || byte_data == `RWA_CMD_WR_RED;
      unique case (byte_data)
        `RWA_CMD_WR_BW:  next_st.xfer = xfer_bw;
        `RWA_CMD_WR_RED: next_st.xfer = xfer_red;
        default:         next_st.xfer = xfer_none;
      endcase
    end else if (byte_valid) begin
      if (st.pidx != 3'h7) begin
        next_st.pidx = st.pidx + 3'h1;
      end
      unique case (st.cmd)
        `RWA_CMD_ENTRY:  next_st.entry = byte_data[2:0];
        `RWA_CMD_BORDER: next_st.border = byte_data;
        `RWA_CMD_RD_OPT: next_st.read_plane = byte_data[0];
        `RWA_CMD_XWIN: begin
          if (st.pidx == 3'h0) next_st.window_x_start = byte_data[5:0];
          if (st.pidx == 3'h1) next_st.window_x_end = byte_data[5:0];
        end
        `RWA_CMD_YWIN: begin
          if (st.pidx == 3'h0) next_st.window_y_start[7:0] = byte_data;
          if (st.pidx == 3'h1) next_st.window_y_start[8] = byte_data[0];
          if (st.pidx == 3'h2) next_st.window_y_end[7:0] = byte_data;
          if (st.pidx == 3'h3) next_st.window_y_end[8] = byte_data[0];
        end
        `RWA_CMD_XCNT: begin
          if (st.pidx == 3'h0) next_st.xcnt = byte_data[5:0];
        end
        `RWA_CMD_YCNT: begin
          if (st.pidx == 3'h0) next_st.ycnt[7:0] = byte_data;
          if (st.pidx == 3'h1) next_st.ycnt[8] = byte_data[0];
        end
        `RWA_CMD_FILL_RED, `RWA_CMD_FILL_BW: begin
          // Invalid size codes leave memory untouched
          if (st.pidx == 3'h0 && byte_data[`RWA_FILL_H_HI:`RWA_FILL_H_LO] != `RWA_H_BAD &&
              byte_data[`RWA_FILL_W_HI:`RWA_FILL_W_LO] <= `RWA_W_MAX_OK) begin
            next_st.fill       = fill_run;
            next_st.busy       = 1'b1;
            next_st.fill_plane = (st.cmd == `RWA_CMD_FILL_RED);
            next_st.fill_first = byte_data[`RWA_FILL_FIRST];
            next_st.fill_h     = fill_height(byte_data[`RWA_FILL_H_HI:`RWA_FILL_H_LO]);
            next_st.fill_w     = fill_width(byte_data[`RWA_FILL_W_HI:`RWA_FILL_W_LO]);
            next_st.fx         = 6'h00;
            next_st.fy         = 9'h000;
            next_st.fxb        = 5'h00;
            next_st.fyb        = 9'h000;
            next_st.xtog       = 1'b0;
            next_st.ytog       = 1'b0;
          end
        end
        default: begin
          if (st.xfer != xfer_none) begin
            next_st.ram_we    = in_window;
            next_st.ram_plane = (st.xfer == xfer_red);
            next_st.ram_x     = st.xcnt;
            next_st.ram_y     = st.ycnt;
            next_st.ram_wdata = byte_data;
            if (!st.entry[`RWA_ENT_AM]) begin
              next_st.xcnt = x_next;
              if (x_wrap) next_st.ycnt = y_next;
            end else begin
              next_st.ycnt = y_next;
              if (y_wrap) next_st.xcnt = x_next;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st                     <= '0;
      st.window_x_start      <= `RWA_XSTART_RST;
      st.window_x_end        <= `RWA_XEND_RST;
      st.window_y_start      <= `RWA_YSTART_RST;
      st.window_y_end        <= `RWA_YEND_RST;
      st.xcnt                <= `RWA_XCNT_RST;
      st.ycnt                <= `RWA_YCNT_RST;
      st.entry               <= `RWA_ENTRY_RST;
      st.border              <= `RWA_BORDER_RST;
      st.border_drive_output <= bd_hiz;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign busy                  = st.busy;
  assign ram_we                = st.ram_we;
  assign ram_plane             = st.ram_plane;
  assign ram_x                 = st.ram_x;
  assign ram_y                 = st.ram_y;
  assign ram_wdata             = st.ram_wdata;
  assign read_plane            = st.read_plane;
  assign window_x_start        = st.window_x_start;
  assign window_x_end          = st.window_x_end;
  assign window_y_start        = st.window_y_start;
  assign window_y_end          = st.window_y_end;
  assign ram_address_counter_x = st.xcnt;
  assign ram_address_counter_y = st.ycnt;
  assign count_direction_bits  = st.entry[1:0];
  assign axis_select_bit       = st.entry[`RWA_ENT_AM];
  assign transfer_active       = st.xfer_open;
  assign border_drive_output   = st.border_drive_output;
endmodule

// ### bench/rwa_cmd_assertions.sv
// Checker for the addressing block, attached to rwa_cmd by bind.
// Assumes clk_en stays high while settings are compared.
`timescale 1ns/1ps
module rwa_cmd_chk
  import rwa_pkg::*;
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       data_cmd,
  input wire logic       busy,
  input wire logic       ram_we,
  input wire logic       ram_plane,
  input wire logic [5:0] ram_x,
  input wire logic [8:0] ram_y,
  input wire logic       read_plane,
  input wire logic [5:0] window_x_start,
  input wire logic [5:0] window_x_end,
  input wire logic [8:0] window_y_start,
  input wire logic [8:0] window_y_end,
  input wire logic [1:0] count_direction_bits,
  input wire logic       axis_select_bit,
  input wire logic       transfer_active,
  input wire rwa_bd_e    border_drive_output
);
  logic       take;
  logic       prm0;
  logic       fcmd;
  logic [7:0] cmd_q;
  logic [2:0] np;

  // ----------------------------------------
  // Command tracking
  // ----------------------------------------
  assign take = clk_en && byte_valid && !busy;
  assign prm0 = take && data_cmd && np == 3'h0;
  assign fcmd = cmd_q[7:1] == 7'h23;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
      np    <= 3'h0;
    end else if (take && !data_cmd) begin
      cmd_q <= byte_data;
      np    <= 3'h0;
    end else if (take && np != 3'h7) begin
      np <= np + 3'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_entry_rst;
    $rose(rstn) |-> count_direction_bits == 2'h3 && !axis_select_bit;
  endproperty
  a_entry_rst: assert property (p_entry_rst) else $error("entry setting wrong after reset");
  property p_rdopt;
    prm0 && cmd_q == 8'h41 |=> read_plane == $past(byte_data[0]);
  endproperty
  a_rdopt: assert property (p_rdopt) else $error("read plane not loaded");
  property p_xwin;
    take && data_cmd && cmd_q == 8'h44 && np == 3'h1 |=> window_x_end == $past(byte_data[5:0]);
  endproperty
  a_xwin: assert property (p_xwin) else $error("x window end not loaded");
  property p_fill_go;
    prm0 && fcmd && byte_data[6:4] != 3'h7 && byte_data[2:0] < 3'h6 |-> ##[1:2] busy;
  endproperty
  a_fill_go: assert property (p_fill_go) else $error("fill did not raise busy");
  property p_fill_bad;
    prm0 && fcmd && (byte_data[6:4] == 3'h7 || byte_data[2:0] > 3'h5) |=> !busy [*3];
  endproperty
  a_fill_bad: assert property (p_fill_bad) else $error("invalid fill ran");
  property p_fill_plane;
    ram_we && fcmd |-> ram_plane == !cmd_q[0];
  endproperty
  a_fill_plane: assert property (p_fill_plane) else $error("fill wrote wrong plane");
  property p_nop;
    take && !data_cmd && byte_data == 8'h7F |=> !transfer_active;
  endproperty
  a_nop: assert property (p_nop) else $error("transfer open after no-op");
  property p_window;
    ram_we && (cmd_q == 8'h24 || cmd_q == 8'h26) |-> ram_x >= window_x_start && ram_x <= window_x_end
      && ram_y >= window_y_start && ram_y <= window_y_end;
  endproperty
  a_window: assert property (p_window) else $error("write outside window");
  property p_border;
    prm0 && cmd_q == 8'h3C && byte_data[7:6] == 2'h1 |=>
      ##1 border_drive_output == rwa_bd_e'(4'h5 + {2'h0, $past(byte_data[5:4], 2)});
  endproperty
  a_border: assert property (p_border) else $error("fixed border level wrong");

  c_fill: cover property ($rose(busy));
  c_write: cover property (ram_we && transfer_active);
  c_nop: cover property (take && !data_cmd && byte_data == 8'h7F);
endmodule

bind rwa_cmd rwa_cmd_chk i_chk (
  .clock, .rstn, .clk_en, .byte_valid, .byte_data, .data_cmd, .busy, .ram_we, .ram_plane, .ram_x, .ram_y,
  .read_plane, .window_x_start, .window_x_end, .window_y_start, .window_y_end, .count_direction_bits,
  .axis_select_bit, .transfer_active, .border_drive_output
);

// ### bench/rwa_host.sv
// Host model: sends command and parameter bytes over the byte port.
// Assumes every call starts just after a rising clock edge.
`timescale 1ns/1ps
module rwa_host (
  input  wire logic  clock,
  output logic       byte_valid,
  output logic [7:0] byte_data,
  output logic       data_cmd
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    data_cmd   = 1'b1;
  end

  task automatic put(input logic dc, input logic [7:0] b);
    data_cmd   = dc;
    byte_data  = b;
    byte_valid = 1'b1;
    @(posedge clock);
    #1;
  endtask

  // Nine-bit values go low byte first, bit 8 next
  task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] a = 8'h00, b = 8'h00,
                     input logic [7:0] d = 8'h00, e = 8'h00);
    logic [7:0] p [4];
    p = '{a, b, d, e};
    put(1'b0, c);
    for (int i = 0; i < n; i++) begin
      put(1'b1, p[i]);
    end
  endtask

  // Released lines flip so a stale byte never looks current
  task automatic idle(input int n);
    byte_valid = 1'b0;
    byte_data  = ~byte_data;
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
endmodule

// ### bench/testbench.sv
// Testbench of the addressing block: host model, write monitor, scenarios.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module testbench;
  import rwa_pkg::*;
  localparam int COLS = 4;
  localparam int ROWS = 8;
  // Border byte, red flag in bit 4, expected drive code
  localparam logic [15:0] BT [12] = '{16'hC009, 16'h8004, 16'h4005, 16'h5006, 16'h6007, 16'h7008,
                                      16'h0014, 16'h0000, 16'h0410, 16'h0101, 16'h0202, 16'h0303};
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        clk_en = 1'b1;
  logic        red_phase = 1'b0;
  logic        byte_valid, data_cmd, busy, ram_we, ram_plane, read_plane, transfer_active, axis_select_bit;
  logic [7:0]  byte_data, ram_wdata;
  logic [5:0]  ram_x, window_x_start, window_x_end, ram_address_counter_x;
  logic [8:0]  ram_y, window_y_start, window_y_end, ram_address_counter_y;
  logic [1:0]  count_direction_bits;
  rwa_bd_e     border_drive_output;
  logic [23:0] wq [$];
  int          checked = 0;
  int          n_mismatch = 0;

  always #2 clock = ~clock;
  // Sampled mid-cycle, where the registered write pulse has settled
  always @(negedge clock) begin
    if (ram_we === 1'b1) wq.push_back({ram_plane, ram_x, ram_y, ram_wdata});
  end

  rwa_host i_host (.clock(clock), .byte_valid(byte_valid), .byte_data(byte_data), .data_cmd(data_cmd));
  rwa_cmd #(.FILL_COLS(COLS), .FILL_ROWS(ROWS)) i_dut (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .byte_valid(byte_valid), .byte_data(byte_data),
    .data_cmd(data_cmd), .red_phase(red_phase), .busy(busy), .ram_we(ram_we), .ram_plane(ram_plane),
    .ram_x(ram_x), .ram_y(ram_y), .ram_wdata(ram_wdata), .read_plane(read_plane),
    .window_x_start(window_x_start), .window_x_end(window_x_end), .window_y_start(window_y_start),
    .window_y_end(window_y_end), .ram_address_counter_x(ram_address_counter_x),
    .ram_address_counter_y(ram_address_counter_y), .count_direction_bits(count_direction_bits),
    .axis_select_bit(axis_select_bit), .transfer_active(transfer_active),
    .border_drive_output(border_drive_output)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [23:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [8:0] adv(input logic [8:0] c, lo, hi, input logic up, output logic wr);
    wr = up ? c == hi : c == lo;
    return wr ? (up ? lo : hi) : (up ? c + 9'h1 : c - 9'h1);
  endfunction

  task automatic tally_and_finish();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("x_start", 24'h00, window_x_start);
    chk("x_end", 24'h15, window_x_end);
    chk("y_start", 24'h000, window_y_start);
    chk("y_end", 24'h127, window_y_end);
    chk("ctr_x", 24'h00, ram_address_counter_x);
    chk("ctr_y", 24'h000, ram_address_counter_y);
    chk("entry", 24'h3, {axis_select_bit, count_direction_bits});
    chk("rd_plane", 24'h0, read_plane);
    chk("border", 24'h9, border_drive_output);
  endtask

  task automatic t_regs();
    i_host.cmd(8'h44, 2, 8'h3F, 8'h2A);
    i_host.cmd(8'h45, 4, 8'hFF, 8'h01, 8'h34, 8'h00);
    i_host.cmd(8'h4E, 1, 8'h3E);
    i_host.cmd(8'h4F, 2, 8'h80, 8'h01);
    i_host.cmd(8'h41, 1, 8'h01);
    i_host.idle(2);
    chk("x_start", 24'h3F, window_x_start);
    chk("x_end", 24'h2A, window_x_end);
    chk("y_start", 24'h1FF, window_y_start);
    chk("y_end", 24'h034, window_y_end);
    chk("ctr_x", 24'h3E, ram_address_counter_x);
    chk("ctr_y", 24'h180, ram_address_counter_y);
    chk("rd_plane", 24'h1, read_plane);
  endtask

  task automatic t_walk(input logic [2:0] m, input logic [7:0] wc);
    logic [5:0] x;
    logic [8:0] y;
    logic       w;
    wq.delete();
    x = m[0] ? 6'h01 : 6'h02;
    y = m[1] ? 9'h101 : 9'h102;
    i_host.cmd(8'h44, 2, 8'h01, 8'h02);
    i_host.cmd(8'h45, 4, 8'h01, 8'h01, 8'h02, 8'h01);
    i_host.cmd(8'h11, 1, {5'h00, m});
    i_host.cmd(8'h4E, 1, {2'h0, x});
    i_host.cmd(8'h4F, 2, y[7:0], {7'h00, y[8]});
    i_host.cmd(wc, 0);
    for (int i = 0; i < 5; i++) begin
      i_host.put(1'b1, 8'hA0 + 8'(i));
    end
    i_host.cmd(8'h7F, 0);
    i_host.put(1'b1, 8'h55);
    i_host.idle(3);
    chk("writes", 24'h5, 24'(wq.size()));
    for (int i = 0; i < 5; i++) begin
      chk("write", {wc[1], x, y, 8'hA0 + 8'(i)}, wq[i]);
      if (m[2]) begin
        y = adv(y, 9'h101, 9'h102, m[1], w);
        if (w) x = 6'(adv({3'h0, x}, 9'h001, 9'h002, m[0], w));
      end else begin
        x = 6'(adv({3'h0, x}, 9'h001, 9'h002, m[0], w));
        if (w) y = adv(y, 9'h101, 9'h102, m[1], w);
      end
    end
    chk("ctr_x", x, ram_address_counter_x);
    chk("ctr_y", y, ram_address_counter_y);
  endtask

  task automatic t_fill(input logic [7:0] c, p, input logic run);
    logic [5:0] x0;
    int         k;
    wq.delete();
    x0 = ram_address_counter_x;
    i_host.cmd(c, 1, p);
    i_host.idle(2);
    chk("busy", run, busy);
    // Refused while busy, so the counter must keep its value
    if (run) i_host.cmd(8'h4E, 1, 8'h05);
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      i_host.idle(1);
      k++;
    end
    chk("busy_end", 24'h0, busy);
    i_host.idle(2);
    chk("count", run ? 24'(COLS * ROWS) : 24'h0, 24'(wq.size()));
    chk("ctr_x", x0, ram_address_counter_x);
    for (int i = 0; i < wq.size(); i++) begin
      chk("fill", {c == 8'h46, 6'(i % COLS), 9'(i / COLS), {8{p[7] ^ 1'(i % COLS) ^ 1'(i / COLS / 8)}}},
          wq[i]);
    end
  endtask

  // Enable low: bytes offered meanwhile must leave the counter alone
  task automatic t_hold();
    logic [5:0] x0;
    x0 = ram_address_counter_x;
    clk_en = 1'b0;
    i_host.cmd(8'h4E, 1, {2'h0, ~x0});
    i_host.idle(2);
    chk("hold_x", x0, ram_address_counter_x);
    clk_en = 1'b1;
  endtask

  task automatic t_border();
    for (int i = 0; i < 12; i++) begin
      red_phase = BT[i][4];
      i_host.cmd(8'h3C, 1, BT[i][15:8]);
      i_host.idle(3);
      chk("border", BT[i][3:0], border_drive_output);
    end
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_hold();
    t_walk(3'h3, 8'h24);
    t_walk(3'h0, 8'h26);
    t_walk(3'h6, 8'h24);
    t_fill(8'h46, 8'h80, 1'b1);
    t_fill(8'h47, 8'h00, 1'b1);
    t_fill(8'h46, 8'h06, 1'b0);
    t_fill(8'h47, 8'h70, 1'b0);
    t_border();
    tally_and_finish();
  end
endmodule
